// file: verilog/histo_core.sv
// histogram ram core: mode decode, address and data paths, host access and wipe
`include "histo_defs.svh"
`timescale 1ns/100ps

module histo_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // mode control, asynchronous pins
    input wire logic [2:0] operation_select_i,
    input wire logic operation_latch_n_i,
    input wire logic wipe_n_i,
    // clocked stream inputs
    input wire logic run_gate_n_i,
    input wire logic [`HR_ADDR_W-1:0] pixel_bus_i,
    input wire logic [`HR_DATA_W-1:0] sample_in_i,
    // host side, asynchronous pins
    input wire logic host_read_n_i,
    input wire logic host_write_n_i,
    input wire logic upper_half_sel_i,
    input wire logic [`HR_ADDR_W-1:0] host_word_index_i,
    input wire logic [`HR_DATA_W-1:0] host_data_bus_i,
    output logic [`HR_DATA_W-1:0] host_data_bus_o,
    output logic host_data_bus_oe_n_o,
    // status
    output logic [2:0] mode_o
);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic latch_n_s, rd_n_s, wr_n_s, wipe_n_s, uws_s;
    logic [2:0] sel_s;
    logic [`HR_ADDR_W-1:0] idx_s;
    logic [`HR_DATA_W-1:0] data_s;

    histo_pin_sync #(.W(5), .RST_VAL(`HR_CTL_SYNC_RST)) ctl_sync (
        .clk_i(clk_i), .rst_n_i(rst_n_i),
        .a_i({operation_latch_n_i, host_read_n_i, host_write_n_i, wipe_n_i, upper_half_sel_i}),
        .q_o({latch_n_s, rd_n_s, wr_n_s, wipe_n_s, uws_s})
    );
    histo_pin_sync #(.W(3), .RST_VAL(`HR_SEL_SYNC_RST)) sel_sync (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(operation_select_i), .q_o(sel_s));
    // index and data are only used at a strobe edge, long after they settle
    histo_pin_sync #(.W(`HR_ADDR_W), .RST_VAL('0)) idx_sync (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(host_word_index_i), .q_o(idx_s));
    histo_pin_sync #(.W(`HR_DATA_W), .RST_VAL('0)) data_sync (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .a_i(host_data_bus_i), .q_o(data_s));

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    histo_pkg::mode_t mode_reg, mode_next;
    logic latch_prev_reg, rd_prev_reg, wr_prev_reg, run_prev_reg;
    logic latch_prev_next, rd_prev_next, wr_prev_next, run_prev_next;
    logic [`HR_ADDR_W-1:0] host_raddr_reg, host_raddr_next, host_waddr_reg, host_waddr_next;
    logic [`HR_ADDR_W-1:0] cnt_reg, cnt_next;
    logic done_reg, done_next;
    logic [`HR_ADDR_W-1:0] addr_p1_reg, addr_p1_next, addr_p2_reg, addr_p2_next;
    logic valid_p1_reg, valid_p1_next, valid_p2_reg, valid_p2_next;
    logic first_p1_reg, first_p1_next, first_p2_reg, first_p2_next;
    logic [`HR_DATA_W-1:0] samp_p1_reg, samp_p1_next, samp_p2_reg, samp_p2_next;
    logic [`HR_DATA_W-1:0] rd_p2_reg, rd_p2_next, result_reg, result_next, out_reg, out_next;

    // ---------------------------------------------------------------
    // decode and control terms
    // ---------------------------------------------------------------
    logic is_async, is_16, dly_mode, run_low, start, latch_rise, rd_fall, wr_fall, wr_rise;
    logic use_cnt, slot_valid, wipe, host_we, we_sync;
    logic [`HR_DATA_W-1:0] ram_rdata, ram_wdata, new_val, shown_val;
    logic [`HR_ADDR_W-1:0] ram_raddr, ram_waddr;
    logic ram_we_lo, ram_we_hi;

    // host modes ignore the clocked pipeline entirely
    assign is_async = (mode_reg == histo_pkg::MODE_ASYNC24) || (mode_reg == histo_pkg::MODE_ASYNC16);
    assign is_16 = (mode_reg == histo_pkg::MODE_ASYNC16);
    assign dly_mode = (mode_reg == histo_pkg::MODE_DELAY) || (mode_reg == histo_pkg::MODE_DLY_SUB);
    assign run_low = !run_gate_n_i;
    assign start = run_low && run_prev_reg && !is_async;
    assign latch_rise = latch_n_s && !latch_prev_reg;
    assign rd_fall = !rd_n_s && rd_prev_reg;
    assign wr_fall = !wr_n_s && wr_prev_reg;
    assign wr_rise = wr_n_s && !wr_prev_reg;
    assign wipe = !wipe_n_s;

    // counter drives the address in delay modes always, in hist acc and lut only while running
    assign use_cnt = dly_mode || (run_low && ((mode_reg == histo_pkg::MODE_HIST_ACC) ||
                     (mode_reg == histo_pkg::MODE_LUT)));
    // a slot is a write that will land three edges on; run gate high blocks it outside delay modes
    always_comb begin
        if (is_async) begin
            slot_valid = 1'b0;
        end else if (use_cnt) begin
            slot_valid = !start && !done_reg;
        end else begin
            slot_valid = run_low && ((mode_reg == histo_pkg::MODE_HIST) ||
                         (mode_reg == histo_pkg::MODE_BIN_ACC));
        end
    end

    // ---------------------------------------------------------------
    // adder and output select for the third stage
    // ---------------------------------------------------------------
    always_comb begin
        new_val = samp_p2_reg;
        shown_val = rd_p2_reg;
        case (mode_reg)
            histo_pkg::MODE_HIST: begin
                new_val = rd_p2_reg + 24'h000001;
                shown_val = new_val;
            end
            histo_pkg::MODE_HIST_ACC: begin
                // running sum restarts with the first word after the run gate falls
                new_val = (first_p2_reg ? 24'h000000 : result_reg) + rd_p2_reg;
                shown_val = new_val;
            end
            histo_pkg::MODE_BIN_ACC: begin
                new_val = rd_p2_reg + samp_p2_reg;
                shown_val = new_val;
            end
            histo_pkg::MODE_DLY_SUB: begin
                shown_val = rd_p2_reg - samp_p2_reg;
            end
            default: begin
                new_val = samp_p2_reg;
                shown_val = rd_p2_reg;
            end
        endcase
        if (!valid_p2_reg) begin
            shown_val = rd_p2_reg;
        end
    end

    assign we_sync = valid_p2_reg && !is_async && !wipe;
    // host write lands on the trailing edge so the data has settled; never while wiping
    assign host_we = is_async && wr_rise && !wipe;

    // ---------------------------------------------------------------
    // ram port muxing
    // ---------------------------------------------------------------
    always_comb begin
        if (is_async) begin
            ram_raddr = host_raddr_reg;
            ram_waddr = host_waddr_reg;
            ram_wdata = (is_16 && uws_s) ? {data_s[`HR_NARROW_MSB:0], 16'h0000} : data_s;
            ram_we_lo = host_we && !(is_16 && uws_s);
            ram_we_hi = host_we && !(is_16 && !uws_s);
        end else begin
            ram_raddr = addr_p1_reg;
            ram_waddr = addr_p2_reg;
            ram_wdata = new_val;
            ram_we_lo = we_sync;
            ram_we_hi = we_sync;
        end
    end

    histo_bin_ram bin_ram (
        .clk_i(clk_i),
        .clear_i(wipe),
        .we_lo_i(ram_we_lo),
        .we_hi_i(ram_we_hi),
        .waddr_i(ram_waddr),
        .wdata_i(ram_wdata),
        .raddr_i(ram_raddr),
        .rdata_o(ram_rdata)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        latch_prev_next = latch_n_s;
        rd_prev_next = rd_n_s;
        wr_prev_next = wr_n_s;
        run_prev_next = run_gate_n_i;
        mode_next = latch_rise ? histo_pkg::mode_t'(sel_s) : mode_reg;
        host_raddr_next = (is_async && rd_fall) ? idx_s : host_raddr_reg;
        host_waddr_next = (is_async && wr_fall) ? idx_s : host_waddr_reg;
        // counter
        cnt_next = cnt_reg;
        done_next = done_reg;
        if (latch_rise) begin
            done_next = 1'b0;
        end
        if (start) begin
            cnt_next = '0;
            done_next = 1'b0;
        end else if (slot_valid && use_cnt) begin
            if (cnt_reg == `HR_CNT_LAST) begin
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 10'h001;
            end
        end
        // stage one: address and aligned controls
        addr_p1_next = use_cnt ? cnt_reg : pixel_bus_i;
        valid_p1_next = slot_valid;
        first_p1_next = slot_valid && use_cnt && (cnt_reg == 10'h000);
        samp_p1_next = sample_in_i;
        // stage two: ram word, forwarded when the word is being written now
        addr_p2_next = addr_p1_reg;
        valid_p2_next = valid_p1_reg;
        first_p2_next = first_p1_reg;
        samp_p2_next = samp_p1_reg;
        rd_p2_next = (we_sync && (addr_p2_reg == addr_p1_reg)) ? new_val : ram_rdata;
        // stage three and bus output
        result_next = shown_val;
        if (is_async) begin
            if (is_16) begin
                out_next = uws_s ? {16'h0000, ram_rdata[`HR_UPPER_MSB:`HR_UPPER_LSB]} :
                           {8'h00, ram_rdata[`HR_LOWER_MSB:0]};
            end else begin
                out_next = ram_rdata;
            end
        end else begin
            out_next = result_reg;
        end
        if (wipe) begin
            rd_p2_next = '0;
            result_next = '0;
            out_next = '0;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= histo_pkg::MODE_HIST;
            latch_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
            run_prev_reg <= 1'b1;
            host_raddr_reg <= '0;
            host_waddr_reg <= '0;
            cnt_reg <= '0;
            done_reg <= 1'b1;
            addr_p1_reg <= '0;
            addr_p2_reg <= '0;
            valid_p1_reg <= 1'b0;
            valid_p2_reg <= 1'b0;
            first_p1_reg <= 1'b0;
            first_p2_reg <= 1'b0;
            samp_p1_reg <= '0;
            samp_p2_reg <= '0;
            rd_p2_reg <= '0;
            result_reg <= '0;
            out_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            latch_prev_reg <= latch_prev_next;
            rd_prev_reg <= rd_prev_next;
            wr_prev_reg <= wr_prev_next;
            run_prev_reg <= run_prev_next;
            host_raddr_reg <= host_raddr_next;
            host_waddr_reg <= host_waddr_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            addr_p1_reg <= addr_p1_next;
            addr_p2_reg <= addr_p2_next;
            valid_p1_reg <= valid_p1_next;
            valid_p2_reg <= valid_p2_next;
            first_p1_reg <= first_p1_next;
            first_p2_reg <= first_p2_next;
            samp_p1_reg <= samp_p1_next;
            samp_p2_reg <= samp_p2_next;
            rd_p2_reg <= rd_p2_next;
            result_reg <= result_next;
            out_reg <= out_next;
        end
    end

    // read strobe drives the bus in every mode; enable is active low
    assign host_data_bus_oe_n_o = rd_n_s;
    assign host_data_bus_o = out_reg;
    assign mode_o = mode_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence run_idle_s;
        run_gate_n_i[*3];
    endsequence

    cnt_clear_a: assert property (start |=> cnt_reg == 10'h000)
        else $error("counter not cleared after run gate fell");
    cnt_hold_a: assert property (done_reg && !start && !latch_rise && use_cnt |=> cnt_reg == $past(cnt_reg))
        else $error("counter moved after reaching its end");
    mode_load_a: assert property (latch_rise |=> mode_reg == histo_pkg::mode_t'($past(sel_s)))
        else $error("mode not loaded at latch edge");
    wipe_out_a: assert property (wipe ##1 wipe |-> host_data_bus_o == 24'h000000)
        else $error("host bus not zero during wipe");
    index_ignore_a: assert property (!is_async |=> host_waddr_reg == $past(host_waddr_reg))
        else $error("host index taken in a clocked mode");
    hist_incr_a: assert property (we_sync && mode_reg == histo_pkg::MODE_HIST |->
        ram_wdata == 24'(rd_p2_reg + 24'h000001))
        else $error("histogram bin not incremented by one");
    idle_nowrite_a: assert property ((!dly_mode && !is_async && !latch_rise) throughout run_idle_s |-> !we_sync)
        else $error("write while run gate high");
    pix_addr_a: assert property (mode_reg == histo_pkg::MODE_HIST && !is_async && !latch_rise |=>
        addr_p1_reg == $past(pixel_bus_i))
        else $error("histogram address not from pixel bus");
    acc_sum_a: assert property (we_sync && mode_reg == histo_pkg::MODE_HIST_ACC && !first_p2_reg |->
        ram_wdata == 24'(result_reg + rd_p2_reg))
        else $error("running sum not written back");
    host_addr_a: assert property (rd_fall && is_async |=> host_raddr_reg == $past(idx_s))
        else $error("read address not taken at strobe fall");
    half_write_a: assert property (host_we && is_16 && uws_s |-> ram_we_hi && !ram_we_lo)
        else $error("upper half write touched lower bits");

endmodule

// file: verilog/histo_defs.svh
// constants for the histogram ram core: sizes, limits, field positions and reset values
`ifndef HISTO_DEFS_SVH
`define HISTO_DEFS_SVH

// ---------------------------------------------------------------
// array geometry
// ---------------------------------------------------------------
`define HR_DATA_W 24
`define HR_ADDR_W 10
`define HR_WORDS 1024
`define HR_CNT_LAST 10'h3ff

// ---------------------------------------------------------------
// host word halves in the 16-bit host mode
// ---------------------------------------------------------------
`define HR_UPPER_MSB 23
`define HR_UPPER_LSB 16
`define HR_LOWER_MSB 15
`define HR_NARROW_MSB 7

// ---------------------------------------------------------------
// synchroniser reset values: strobes idle high, select idle low
// ---------------------------------------------------------------
`define HR_CTL_SYNC_RST 5'h1e
`define HR_SEL_SYNC_RST 3'h0

`endif

// file: verilog/histo_pkg.sv
// types shared by the histogram ram core
package histo_pkg;

    // ---------------------------------------------------------------
    // operating modes, codes as decoded from the operation select
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_HIST = 3'h0,
        MODE_HIST_ACC = 3'h1,
        MODE_DLY_SUB = 3'h2,
        MODE_LUT = 3'h3,
        MODE_BIN_ACC = 3'h4,
        MODE_DELAY = 3'h5,
        MODE_ASYNC24 = 3'h6,
        MODE_ASYNC16 = 3'h7
    } mode_t;

endpackage

// file: verilog/histo_pin_sync.sv
// two flip-flop synchroniser for a group of pins from outside the clock domain
`timescale 1ns/100ps

module histo_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pins in, synchronised levels out
    input wire logic [W-1:0] a_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= RST_VAL;
            q_reg <= RST_VAL;
        end else begin
            meta_reg <= a_i;
            q_reg <= meta_reg;
        end
    end

    assign q_o = q_reg;

endmodule

// file: verilog/histo_bin_ram.sv
// 1024 x 24 flip-flop array with split write enables and one-cycle wipe
`include "histo_defs.svh"
`timescale 1ns/100ps

module histo_bin_ram (
    // clock
    input wire logic clk_i,
    // wipe: zeroes every word on the edge it is seen
    input wire logic clear_i,
    // write port, lower 16 and upper 8 bits enabled apart
    input wire logic we_lo_i,
    input wire logic we_hi_i,
    input wire logic [`HR_ADDR_W-1:0] waddr_i,
    input wire logic [`HR_DATA_W-1:0] wdata_i,
    // read port, combinational
    input wire logic [`HR_ADDR_W-1:0] raddr_i,
    output logic [`HR_DATA_W-1:0] rdata_o
);

    logic [`HR_DATA_W-1:0] mem_reg [`HR_WORDS];

    // data storage has no reset; the wipe input is the only way to zero it
    always_ff @(posedge clk_i) begin
        if (clear_i) begin
            for (int i = 0; i < `HR_WORDS; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            if (we_lo_i) begin
                mem_reg[waddr_i][`HR_LOWER_MSB:0] <= wdata_i[`HR_LOWER_MSB:0];
            end
            if (we_hi_i) begin
                mem_reg[waddr_i][`HR_UPPER_MSB:`HR_UPPER_LSB] <= wdata_i[`HR_UPPER_MSB:`HR_UPPER_LSB];
            end
        end
    end

    assign rdata_o = mem_reg[raddr_i];

endmodule

// file: dv/histo_host_model.sv
// host processor model driving the asynchronous host pins of the core
`include "histo_defs.svh"
`timescale 1ns/100ps

module histo_host_model (
    // clock that paces the strobes
    input wire logic clk_i,
    // host pins
    output logic host_read_n_o,
    output logic host_write_n_o,
    output logic upper_half_sel_o,
    output logic [`HR_ADDR_W-1:0] host_word_index_o,
    output logic [`HR_DATA_W-1:0] host_data_bus_o,
    input wire logic [`HR_DATA_W-1:0] host_data_bus_i
);
    // idle: both strobes high
    initial begin
        host_read_n_o = 1'b1;
        host_write_n_o = 1'b1;
        upper_half_sel_o = 1'b0;
        host_word_index_o = 10'h000;
        host_data_bus_o = 24'h000000;
    end

    // write cycle; data held past the trailing edge because the core commits there
    task automatic do_write(input logic up, input logic [9:0] idx, input logic [23:0] d);
        @(negedge clk_i);
        upper_half_sel_o = up;
        host_word_index_o = idx;
        host_data_bus_o = d;
        host_write_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        host_write_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
        host_data_bus_o = ~d; // released bus never keeps the stale value
    endtask

    // read cycle; sampled once the synchronisers and read path have settled
    task automatic do_read(input logic up, input logic [9:0] idx, output logic [23:0] d);
        @(negedge clk_i);
        upper_half_sel_o = up;
        host_word_index_o = idx;
        host_read_n_o = 1'b0;
        repeat (6) @(negedge clk_i);
        d = host_data_bus_i;
        host_read_n_o = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

// file: dv/tb.sv
// self-checking bench for the histogram ram core
`timescale 1ns/100ps

module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [2:0] operation_select_i = 3'h0;
    logic operation_latch_n_i = 1'b1;
    logic wipe_n_i = 1'b1;
    logic run_gate_n_i = 1'b1;
    logic [9:0] pixel_bus_i = 10'h000;
    logic [23:0] sample_in_i = 24'h000000;
    logic rd_n, wr_n, up_sel;
    logic [9:0] idx;
    logic [23:0] bus_in, bus_out, rd;
    logic oe_n;
    logic [2:0] mode_o;
    logic [3:0] m;
    int n_errors = 0;
    int checked = 0;

    histo_core DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .operation_select_i(operation_select_i),
        .operation_latch_n_i(operation_latch_n_i), .wipe_n_i(wipe_n_i), .run_gate_n_i(run_gate_n_i),
        .pixel_bus_i(pixel_bus_i), .sample_in_i(sample_in_i), .host_read_n_i(rd_n),
        .host_write_n_i(wr_n), .upper_half_sel_i(up_sel), .host_word_index_i(idx),
        .host_data_bus_i(bus_in), .host_data_bus_o(bus_out), .host_data_bus_oe_n_o(oe_n),
        .mode_o(mode_o));

    histo_host_model host (.clk_i(clk_i), .host_read_n_o(rd_n), .host_write_n_o(wr_n),
        .upper_half_sel_o(up_sel), .host_word_index_o(idx), .host_data_bus_o(bus_in),
        .host_data_bus_i(bus_out));

    // 20 MHz clock
    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk_data(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mode(input string what, input histo_pkg::mode_t exp, input logic [2:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // mode load with the run gate high; select held around the latch rise
    task automatic load_mode(input histo_pkg::mode_t md);
        @(negedge clk_i);
        operation_select_i = md;
        operation_latch_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        operation_latch_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask

    // read one word and compare
    task automatic rd_chk(input string what, input logic up, input logic [9:0] a, input logic [23:0] exp);
        // the bus enable must follow the read strobe while it is held low
        fork
            host.do_read(up, a, rd);
            begin
                repeat (5) @(negedge clk_i);
                chk_data("oe during read", 24'h000000, {23'h000000, oe_n});
            end
        join
        chk_data(what, exp, rd);
    endtask

    // run gate low for n samples on one pixel, then high again
    task automatic run_for(input int n, input logic [9:0] px);
        @(negedge clk_i);
        pixel_bus_i = px;
        run_gate_n_i = 1'b0;
        repeat (n) @(negedge clk_i);
        run_gate_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask

    // watchdog, several times the expected run length
    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end

    initial begin
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        chk_mode("mode after reset", histo_pkg::MODE_HIST, mode_o);
        chk_data("oe after reset", 24'h000001, {23'h000000, oe_n});
        // every code decodes to its own mode
        for (m = 4'h0; m < 4'h8; m++) begin
            load_mode(histo_pkg::mode_t'(m[2:0]));
            chk_mode("decoded mode", histo_pkg::mode_t'(m[2:0]), mode_o);
        end
        // wipe with run gate high and strobes idle
        wipe_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        wipe_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // 16-bit host: each half written alone
        host.do_write(1'b1, 10'h005, 24'h0000ab);
        rd_chk("upper half", 1'b1, 10'h005, 24'h0000ab);
        rd_chk("lower half after upper write", 1'b0, 10'h005, 24'h000000);
        host.do_write(1'b0, 10'h005, 24'h003456);
        rd_chk("upper kept", 1'b1, 10'h005, 24'h0000ab);
        rd_chk("lower half", 1'b0, 10'h005, 24'h003456);
        load_mode(histo_pkg::MODE_ASYNC24);
        rd_chk("joined word", 1'b0, 10'h005, 24'hab3456);
        host.do_write(1'b1, 10'h009, 24'h5a5a5a);
        rd_chk("full word", 1'b0, 10'h009, 24'h5a5a5a);
        rd_chk("wiped word", 1'b0, 10'h007, 24'h000000);
        // histogram: three hits on one bin, then lookup with gate high
        load_mode(histo_pkg::MODE_HIST);
        run_for(3, 10'h007);
        chk_data("lookup after run", 24'h000003, bus_out);
        host.do_write(1'b0, 10'h007, 24'hffffff);
        load_mode(histo_pkg::MODE_ASYNC24);
        rd_chk("bin count", 1'b0, 10'h007, 24'h000003);
        // cumulative sums over the whole array, counter stops at the last word
        load_mode(histo_pkg::MODE_HIST_ACC);
        run_for(1100, 10'h000);
        load_mode(histo_pkg::MODE_ASYNC24);
        rd_chk("sum at 5", 1'b0, 10'h005, 24'hab3456);
        rd_chk("sum at 7", 1'b0, 10'h007, 24'hab3459);
        rd_chk("sum at 9", 1'b0, 10'h009, 24'h058eb3);
        rd_chk("sum at last", 1'b0, 10'h3ff, 24'h058eb3);
        // bin accumulate: two samples added into an empty bin, then looked up
        load_mode(histo_pkg::MODE_BIN_ACC);
        sample_in_i = 24'h000010;
        run_for(2, 10'h002);
        chk_data("bin sum shown", 24'h000020, bus_out);
        load_mode(histo_pkg::MODE_ASYNC24);
        rd_chk("bin sum stored", 1'b0, 10'h002, 24'h000020);
        give_verdict();
    end
endmodule
